//--- hdl/dscm_command_map.v
// Serial command map of the drive with checksum generation and checking
`timescale 1ns/10ps
`include "dscm_defines.vh"
module dscm_command_map (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  // Message byte stream for checksum
  input wire msg_start,
  input wire msg_byte_valid,
  input wire [7:0] msg_byte,
  output wire msg_byte_ready,
  output wire [15:0] crc_value,
  output wire crc_done,
  input wire [15:0] rx_check,
  output reg crc_match,
  // Check value serialiser
  input wire tx_crc_load,
  input wire tx_byte_ready,
  output reg tx_byte_valid,
  output reg [7:0] tx_byte,
  // Register access
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg reg_ack,
  output reg reg_err,
  // Parameter access
  output reg param_rd,
  output reg param_wr,
  output reg [7:0] param_group,
  output reg [7:0] param_index,
  output reg [15:0] param_wdata,
  input wire [15:0] param_rdata,
  // Drive side
  input wire fault_event,
  input wire [15:0] fault_code,
  output reg run_pulse,
  output reg stop_pulse,
  output reg jog_mode,
  output reg running,
  output reg forward_direction,
  output reg reverse_direction,
  output reg [1:0] accel_set,
  output reg [3:0] step_speed,
  output reg link_sel_en,
  output reg [15:0] freq_setpoint,
  output reg external_fault_input,
  output reg fault_reset_pulse
);
  reg [15:0] error_code;
  reg [7:0] tx_high;
  reg tx_second;
  reg param_wait;
  wire is_param;
  wire take_wr;
  wire take_rd;
  wire wr_cmd;
  wire wr_ctrl;

  // =========================================
  // Checksum engine
  dscm_crc16 u_crc (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .crc_start(msg_start),
    .byte_valid(msg_byte_valid),
    .byte_data(msg_byte),
    .byte_ready(msg_byte_ready),
    .crc_value(crc_value),
    .crc_done(crc_done)
  );

  // =========================================
  // Address classification
  function is_cmd_addr;
    input [15:0] a;
    begin
      is_cmd_addr = (a == `DSCM_ADDR_CMD) || (a == `DSCM_ADDR_FREQ) ||
        (a == `DSCM_ADDR_CTRL) || (a == `DSCM_ADDR_ERR);
    end
  endfunction

  assign is_param = !is_cmd_addr(reg_addr) && (reg_addr[15:8] < 8'h20);

  // =========================================
  // Request decode, nothing taken while a parameter read is pending
  assign take_wr = reg_wr && !param_wait;
  assign take_rd = reg_rd && !reg_wr && !param_wait;
  assign wr_cmd = take_wr && (reg_addr == `DSCM_ADDR_CMD);
  assign wr_ctrl = take_wr && (reg_addr == `DSCM_ADDR_CTRL);

  // =========================================
  // Two-bit field of the command word
  function [1:0] field2;
    input [15:0] w;
    input integer lsb;
    begin
      field2 = w[lsb +: 2];
    end
  endfunction

  // =========================================
  // Checksum compare
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      crc_match <= 1'b0;
    end else if (clk_en) begin
      if (msg_start) begin
        crc_match <= 1'b0;
      end else if (crc_done) begin
        crc_match <= (crc_value == rx_check);
      end
    end
  end

  // =========================================
  // Check value serialiser
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_byte_valid <= 1'b0;
      tx_byte <= 8'h00;
      tx_high <= 8'h00;
      tx_second <= 1'b0;
    end else if (clk_en) begin
      if (tx_crc_load) begin
        tx_byte <= crc_value[7:0];
        tx_high <= crc_value[15:8];
        tx_byte_valid <= 1'b1;
        tx_second <= 1'b1;
      end else if (tx_byte_valid && tx_byte_ready) begin
        if (tx_second) begin
          tx_byte <= tx_high;
          tx_second <= 1'b0;
        end else begin
          tx_byte_valid <= 1'b0;
        end
      end
    end
  end

  // =========================================
  // Register writes and reads
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `DSCM_REG_RESET;
      reg_ack <= 1'b0;
      reg_err <= 1'b0;
      param_rd <= 1'b0;
      param_wr <= 1'b0;
      param_group <= 8'h00;
      param_index <= 8'h00;
      param_wdata <= `DSCM_REG_RESET;
      param_wait <= 1'b0;
      freq_setpoint <= `DSCM_REG_RESET;
      external_fault_input <= 1'b0;
      fault_reset_pulse <= 1'b0;
    end else if (clk_en) begin
      reg_ack <= 1'b0;
      reg_err <= 1'b0;
      param_rd <= 1'b0;
      param_wr <= 1'b0;
      fault_reset_pulse <= 1'b0;
      if (param_wait) begin
        reg_rdata <= param_rdata;
        reg_ack <= 1'b1;
        param_wait <= 1'b0;
      end else if (take_wr) begin
        reg_ack <= 1'b1;
        if (reg_addr == `DSCM_ADDR_CMD) begin
          // Decoded in the command word process
        end else if (reg_addr == `DSCM_ADDR_FREQ) begin
          freq_setpoint <= reg_wdata;
        end else if (reg_addr == `DSCM_ADDR_CTRL) begin
          if (reg_wdata[`DSCM_EF_BIT]) begin
            external_fault_input <= 1'b1;
          end
          if (reg_wdata[`DSCM_RST_BIT]) begin
            fault_reset_pulse <= 1'b1;
            external_fault_input <= reg_wdata[`DSCM_EF_BIT];
          end
        end else if (is_param) begin
          param_wr <= 1'b1;
          param_group <= reg_addr[15:8];
          param_index <= reg_addr[7:0];
          param_wdata <= reg_wdata;
        end else begin
          reg_err <= 1'b1;
        end
      end else if (take_rd) begin
        if (reg_addr == `DSCM_ADDR_ERR) begin
          reg_rdata <= error_code;
          reg_ack <= 1'b1;
        end else if (is_param) begin
          param_rd <= 1'b1;
          param_group <= reg_addr[15:8];
          param_index <= reg_addr[7:0];
          param_wait <= 1'b1;
        end else begin
          reg_rdata <= `DSCM_REG_RESET;
          reg_ack <= 1'b1;
          reg_err <= 1'b1;
        end
      end
    end
  end

  // =========================================
  // Fault status, a new fault wins over a reset
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      error_code <= `DSCM_ERR_NONE;
    end else if (clk_en) begin
      if (fault_event && (fault_code != `DSCM_ERR_NONE)) begin
        error_code <= fault_code;
      end else if (wr_ctrl && reg_wdata[`DSCM_EF_BIT]) begin
        error_code <= `DSCM_ERR_EXT;
      end else if (wr_ctrl && reg_wdata[`DSCM_RST_BIT]) begin
        error_code <= `DSCM_ERR_NONE;
      end
    end
  end

  // =========================================
  // Command word decode
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      run_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      jog_mode <= 1'b0;
      running <= 1'b0;
      forward_direction <= 1'b1;
      reverse_direction <= 1'b0;
      accel_set <= 2'h0;
      step_speed <= 4'h0;
      link_sel_en <= 1'b0;
    end else if (clk_en) begin
      run_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      if (wr_cmd) begin
        case (field2(reg_wdata, `DSCM_RUN_LSB))
          `DSCM_RUN_STOP: begin
            stop_pulse <= 1'b1;
            running <= 1'b0;
            jog_mode <= 1'b0;
          end
          `DSCM_RUN_RUN: begin
            run_pulse <= 1'b1;
            running <= 1'b1;
            jog_mode <= 1'b0;
          end
          `DSCM_RUN_JOG: begin
            run_pulse <= 1'b1;
            running <= 1'b1;
            jog_mode <= 1'b1;
          end
          default: begin
          end
        endcase
        case (field2(reg_wdata, `DSCM_DIR_LSB))
          `DSCM_DIR_FWD: begin
            forward_direction <= 1'b1;
            reverse_direction <= 1'b0;
          end
          `DSCM_DIR_REV: begin
            forward_direction <= 1'b0;
            reverse_direction <= 1'b1;
          end
          `DSCM_DIR_TOG: begin
            forward_direction <= reverse_direction;
            reverse_direction <= forward_direction;
          end
          default: begin
          end
        endcase
        link_sel_en <= reg_wdata[`DSCM_LINK_EN_BIT];
        if (reg_wdata[`DSCM_LINK_EN_BIT]) begin
          accel_set <= field2(reg_wdata, `DSCM_ACC_LSB);
          step_speed <= reg_wdata[`DSCM_STEP_LSB+3:`DSCM_STEP_LSB];
        end
      end
    end
  end
endmodule // dscm_command_map

//--- hdl/dscm_crc16.v
// Bit-serial RTU checksum engine, one shift step per enabled clock
`timescale 1ns/10ps
`include "dscm_defines.vh"
module dscm_crc16 (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  // Byte stream
  input wire crc_start,
  input wire byte_valid,
  input wire [7:0] byte_data,
  output wire byte_ready,
  // Result
  output reg [15:0] crc_value,
  output reg crc_done
);
  reg [3:0] steps_left;
  reg [15:0] next_crc;

  // =========================================
  // Shift step
  always @* begin
    next_crc = {1'b0, crc_value[15:1]};
    if (crc_value[0]) begin
      next_crc = next_crc ^ `DSCM_CRC_POLY;
    end
  end

  assign byte_ready = (steps_left == 4'h0) && !crc_start;

  // =========================================
  // Accumulator
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      crc_value <= `DSCM_CRC_INIT;
      steps_left <= 4'h0;
      crc_done <= 1'b0;
    end else if (clk_en) begin
      crc_done <= 1'b0;
      if (crc_start) begin
        crc_value <= `DSCM_CRC_INIT;
        steps_left <= 4'h0;
      end else if (steps_left != 4'h0) begin
        crc_value <= next_crc;
        steps_left <= steps_left - 4'h1;
        crc_done <= (steps_left == 4'h1);
      end else if (byte_valid) begin
        crc_value <= {crc_value[15:8], crc_value[7:0] ^ byte_data};
        steps_left <= `DSCM_CRC_STEPS;
      end
    end
  end
endmodule // dscm_crc16

//--- hdl/dscm_defines.vh
// Register addresses, field positions and reset values of the command map
`ifndef DSCM_DEFINES_VH
`define DSCM_DEFINES_VH
`define DSCM_ADDR_CMD 16'h2000
`define DSCM_ADDR_FREQ 16'h2001
`define DSCM_ADDR_CTRL 16'h2002
`define DSCM_ADDR_ERR 16'h2100
`define DSCM_CRC_INIT 16'hFFFF
`define DSCM_CRC_POLY 16'hA001
`define DSCM_CRC_STEPS 4'h8
`define DSCM_RUN_LSB 0
`define DSCM_DIR_LSB 4
`define DSCM_ACC_LSB 6
`define DSCM_STEP_LSB 8
`define DSCM_LINK_EN_BIT 12
`define DSCM_EF_BIT 0
`define DSCM_RST_BIT 1
`define DSCM_RUN_NONE 2'h0
`define DSCM_RUN_STOP 2'h1
`define DSCM_RUN_RUN 2'h2
`define DSCM_RUN_JOG 2'h3
`define DSCM_DIR_NONE 2'h0
`define DSCM_DIR_FWD 2'h1
`define DSCM_DIR_REV 2'h2
`define DSCM_DIR_TOG 2'h3
`define DSCM_ERR_NONE 16'h0000
`define DSCM_ERR_EXT 16'h0006
`define DSCM_REG_RESET 16'h0000
`endif

//--- testbench/dscm_command_map_properties.sv
// Concurrent checks on the command map ports
`timescale 1ns/10ps
module dscm_command_map_properties (
  // Clock and reset
  input logic mclk,
  input logic reset_n,
  // Checksum
  input logic msg_start,
  input logic msg_byte_valid,
  input logic msg_byte_ready,
  input logic [15:0] crc_value,
  input logic crc_done,
  // Register access
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_ack,
  input logic param_rd,
  input logic [7:0] param_group,
  input logic [7:0] param_index,
  // Drive side
  input logic run_pulse,
  input logic running,
  input logic [3:0] step_speed,
  input logic external_fault_input
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire w0 = reg_wr && !param_rd;
  wire wc = w0 && reg_addr == 16'h2000;
  chk_preset_ones: assert property (msg_start |=> crc_value == 16'hFFFF)
    else $error("checksum not preset");
  chk_done_nine: assert property (msg_byte_valid && msg_byte_ready && !msg_start
    |=> (!crc_done) [*7] ##[1:3] crc_done) else $error("byte steps wrong");
  chk_busy_ready: assert property (msg_byte_valid && msg_byte_ready && !msg_start
    |=> !msg_byte_ready) else $error("ready stayed high while busy");
  chk_run_cmd: assert property (wc && reg_wdata[1:0] == 2'h2 |=> run_pulse && running)
    else $error("run code ignored");
  chk_link_gate: assert property (wc && !reg_wdata[12] |=> $stable(step_speed))
    else $error("step speed not gated");
  chk_step_load: assert property (wc && reg_wdata[12]
    |=> step_speed == $past(reg_wdata[11:8])) else $error("step speed wrong");
  chk_fault_set: assert property (w0 && reg_addr == 16'h2002 && reg_wdata[0]
    |=> external_fault_input) else $error("external fault not set");
  chk_param_addr: assert property (reg_rd && !reg_wr && !param_rd && reg_addr[15:8] < 8'h20
    |=> param_rd && {param_group, param_index} == $past(reg_addr)) else $error("param address");
  chk_param_ack: assert property (param_rd |=> reg_ack)
    else $error("param read unanswered");
  cov_crc: cover property (crc_done);
  cov_param: cover property (param_rd);
  cov_run: cover property (run_pulse);
endmodule // dscm_command_map_properties
bind dscm_command_map dscm_command_map_properties dscm_command_map_properties_inst (
  .mclk(mclk),
  .reset_n(reset_n),
  .msg_start(msg_start),
  .msg_byte_valid(msg_byte_valid),
  .msg_byte_ready(msg_byte_ready),
  .crc_value(crc_value),
  .crc_done(crc_done),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_ack(reg_ack),
  .param_rd(param_rd),
  .param_group(param_group),
  .param_index(param_index),
  .run_pulse(run_pulse),
  .running(running),
  .step_speed(step_speed),
  .external_fault_input(external_fault_input)
);

//--- testbench/dscm_command_map_test.sv
// Self-checking bench for the drive command map
`timescale 1ns/10ps
module dscm_command_map_test;
  logic mclk, reset_n, clk_en, tx_crc_load, tx_byte_ready, fault_event, e;
  logic reg_wr, reg_rd, reg_ack, reg_err, msg_start, msg_byte_valid, msg_byte_ready, crc_done;
  logic crc_match, tx_byte_valid, run_pulse, stop_pulse, jog_mode, running, link_sel_en;
  logic forward_direction, reverse_direction, external_fault_input, fault_reset_pulse;
  logic param_rd, param_wr;
  logic [1:0] accel_set;
  logic [3:0] step_speed;
  logic [7:0] msg_byte, tx_byte, param_group, param_index;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, crc_value, param_wdata, freq_setpoint;
  logic [15:0] rx_check, param_rdata, fault_code, q;
  int num_errors = 0, checks_done = 0, cycles = 0;
  dscm_command_map dscm_command_map_inst (.*, .clk_en(clk_en));
  dscm_master_model dscm_master_model_inst (.*);
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict;
    end
  end
  // ==========
  // Helpers
  task automatic chk(input string n, input logic [15:0] x, y);
    checks_done++;
    if (x !== y) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, d);
    dscm_master_model_inst.req(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [15:0] a);
    dscm_master_model_inst.req(1'b0, a, 16'h0000, q, e);
  endtask
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction
  // ==========
  // Scenarios
  task automatic t_crc;
    logic [7:0] m [6] = '{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02};
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (m[i]) c = fold(c, m[i]);
    rx_check = c;
    dscm_master_model_inst.start();
    chk("preset", 16'hFFFF, crc_value);
    foreach (m[i]) dscm_master_model_inst.put(m[i]);
    chk("check value", c, crc_value);
    chk("example value", 16'hF76F, crc_value);
    chk("ready", 1'b1, msg_byte_ready);
    @(posedge mclk);
    #1 chk("match", 1'b1, crc_match);
    tx_crc_load = 1'b1;
    @(posedge mclk);
    #1 tx_crc_load = 1'b0;
    chk("tx low", {1'b1, c[7:0]}, {tx_byte_valid, tx_byte});
    @(posedge mclk);
    #1 chk("tx high", c[15:8], tx_byte);
    @(posedge mclk);
    #1 chk("tx end", 1'b0, tx_byte_valid);
    dscm_master_model_inst.start();
    chk("re-preset", 16'hFFFF, crc_value);
    $display("checksum test done");
  endtask
  task automatic t_cmd;
    for (int i = 0; i < 4; i++) begin
      wr(16'h2000, 16'h1000 | 16'(i * 16'h0151));
      chk("run", i >= 2, run_pulse);
      chk("stop", i == 1, stop_pulse);
      chk("jog", i == 3, jog_mode);
      chk("running", i >= 2, running);
      chk("fwd", i != 2, forward_direction);
      chk("rev", i == 2, reverse_direction);
      chk("accel", i, accel_set);
      chk("step", i, step_speed);
      chk("link", 1'b1, link_sel_en);
    end
    wr(16'h2000, 16'h0A80);
    chk("step kept", 16'h0003, step_speed);
    chk("accel kept", 16'h0003, accel_set);
    chk("link off", 1'b0, link_sel_en);
    $display("command test done");
  endtask
  task automatic t_ctrl;
    wr(16'h2002, 16'h0001);
    chk("ext fault", 1'b1, external_fault_input);
    rd(16'h2100);
    chk("err code", 16'h0006, q);
    wr(16'h2100, 16'h0000);
    rd(16'h2100);
    chk("err kept", 16'h0006, q);
    wr(16'h2002, 16'h0002);
    chk("reset pulse", 1'b1, fault_reset_pulse);
    chk("ext clear", 1'b0, external_fault_input);
    rd(16'h2100);
    chk("err none", 16'h0000, q);
    @(posedge mclk);
    #1 fault_code = 16'h000D;
    fault_event = 1'b1;
    @(posedge mclk);
    #1 fault_event = 1'b0;
    rd(16'h2100);
    chk("ground", 16'h000D, q);
    $display("control test done");
  endtask
  task automatic t_map;
    wr(16'h2001, 16'h1770);
    chk("freq", 16'h1770, freq_setpoint);
    param_rdata = 16'h1388;
    rd(16'h0401);
    chk("group", 16'h0004, param_group);
    chk("index", 16'h0001, param_index);
    chk("param data", 16'h1388, q);
    rd(16'h2000);
    chk("wo read", 1'b1, e);
    wr(16'h0500, 16'h1388);
    chk("param wr", 1'b1, param_wr);
    chk("wr group", 16'h0005, param_group);
    chk("wr index", 16'h0000, param_index);
    chk("wr data", 16'h1388, param_wdata);
    clk_en = 1'b0;
    wr(16'h2001, 16'h0BB8);
    clk_en = 1'b1;
    chk("frozen freq", 16'h1770, freq_setpoint);
    $display("map test done");
  endtask
  initial begin
    {reset_n, tx_crc_load, fault_event} = 3'h0;
    tx_byte_ready = 1'b1;
    clk_en = 1'b1;
    {rx_check, param_rdata, fault_code} = 48'h0;
    repeat (8) @(posedge mclk);
    #1 reset_n = 1'b1;
    t_crc;
    t_cmd;
    t_ctrl;
    t_map;
    give_verdict;
  end
endmodule // dscm_command_map_test

//--- testbench/dscm_master_model.sv
// Serial bus master model issuing register requests and message bytes
`timescale 1ns/10ps
module dscm_master_model (
  // Clock
  input logic mclk,
  // Register requests
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input logic reg_ack,
  input logic [15:0] reg_rdata,
  input logic reg_err,
  // Message bytes
  output logic msg_start,
  output logic msg_byte_valid,
  output logic [7:0] msg_byte,
  input logic crc_done
);
  initial begin
    {reg_wr, reg_rd, msg_start, msg_byte_valid} = 4'h0;
    {reg_addr, reg_wdata, msg_byte} = 40'h0;
  end
  // One word per request, released lines show inverted data
  task automatic req(input logic wr, input logic [15:0] a, d, output logic [15:0] q,
      output logic e);
    int n;
    @(posedge mclk);
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, d};
    @(posedge mclk);
    #1 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
    n = 0;
    while (!reg_ack && n < 4) begin
      @(posedge mclk);
      #1 n++;
    end
    q = reg_rdata;
    e = reg_err;
  endtask
  task automatic start;
    @(posedge mclk);
    #1 msg_start = 1'b1;
    @(posedge mclk);
    #1 msg_start = 1'b0;
  endtask
  task automatic put(input logic [7:0] b);
    int n;
    @(posedge mclk);
    #1 {msg_byte_valid, msg_byte} = {1'b1, b};
    @(posedge mclk);
    #1 {msg_byte_valid, msg_byte} = {1'b0, ~b};
    n = 0;
    while (!crc_done && n < 12) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
endmodule // dscm_master_model
